// ==== rtl/paged_serial_flash_spi_port.sv ====
/*
 * Serial slave front end of a paged flash: bit and byte framing on the
 * serial clock, command decode and checks on the system clock, and the
 * array engine. Assumes the serial clock is idle between frames and the
 * master keeps select high while it leaves the clock floating.
 */
`default_nettype none

module paged_serial_flash_spi_port
    import flash_spi_pkg::*;
#(
    parameter int ADDR_W = ADDR_BITS
) (
    // System clock and hardware reset
    input  wire logic CLOCK,
    input  wire logic RST_N,
    // Serial link from the bus master
    input  wire logic SERIAL_CLOCK,
    input  wire logic CHIP_SELECT_N,
    input  wire logic SERIAL_IN,
    input  wire logic WRITE_PROTECT_N,
    output logic      SERIAL_OUT,
    output logic      SERIAL_OUT_EN,
    // Device state
    output logic      POWER_ACTIVE,
    output logic      BUSY
);

    typedef enum {
        S_IDLE, S_CMD, S_ADDR, S_DATA, S_STAT_IN, S_READ, S_SKIP
    } frame_e;

    // Link domain
    logic              frame_rst_n;
    logic              first;
    logic [2:0]        bit_cnt;
    logic [2:0]        next_bit_cnt;
    logic              rx_aligned;
    logic              rx_tgl;
    logic [BYTE_W-1:0] rx_sh;
    logic [BYTE_W-1:0] rx_byte;
    logic [BYTE_W-1:0] tx_sh;

    // System domain
    logic              cs_s1, cs_s2, cs_s3, cs_s4;
    // Idle-high copy of select, so power state shows no false select
    logic              sel_s1, sel_s2;
    logic              tg_s1, tg_s2, tg_s3;
    logic              al_s1, al_s2;
    logic              wp_s1, wp_s2;
    logic              selected;
    logic              cs_fall;
    logic              frame_end;
    logic              byte_evt;
    frame_e            state;
    logic [7:0]        opc;
    logic [23:0]       addr;
    logic [23:0]       next_addr;
    logic [1:0]        addr_cnt;
    logic [PAGE_W-1:0] data_cnt;
    logic              data_seen;
    logic [BYTE_W-1:0] stat_new;
    logic              stat_seen;
    logic              armed;
    logic              wel;
    logic [PROT_W-1:0] protect_size;
    logic              status_lock;
    logic [BYTE_W-1:0] status;
    logic [BYTE_W-1:0] tx_byte;
    logic [ADDR_W-1:0] rd_ptr;
    logic              refresh;
    logic              accept;
    logic              frozen;
    logic              locked;

    // Engine handshake
    logic              eng_start;
    op_e               eng_op;
    logic              buf_clr;
    logic              buf_wr;
    logic [PAGE_W-1:0] buf_idx;
    logic [BYTE_W-1:0] buf_data;
    logic [BYTE_W-1:0] rd_data;
    logic              eng_busy;
    logic              eng_done;

    function automatic logic takes_addr(logic [7:0] c);
        return c == CMD_READ || c == CMD_PAGE_WRITE ||
               c == CMD_PAGE_PROG || c == CMD_PAGE_ERASE ||
               c == CMD_SUB_ERASE || c == CMD_SECT_ERASE;
    endfunction

    function automatic logic takes_data(logic [7:0] c);
        return c == CMD_PAGE_WRITE || c == CMD_PAGE_PROG;
    endfunction

    // Select high or reset clears framing and the output asynchronously
    assign frame_rst_n  = RST_N & ~CHIP_SELECT_N;
    assign next_bit_cnt = first ? BIT_FIRST : bit_cnt + 3'h1;

    // Marks the first clock edge of a new selection
    always_ff @(posedge SERIAL_CLOCK or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            first <= 1'b1;
        end else begin
            first <= 1'b0;
        end
    end

    // Counter is not cleared by select, so alignment survives the frame
    always_ff @(posedge SERIAL_CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            bit_cnt    <= BIT_ZERO;
            rx_aligned <= 1'b1;
            rx_sh      <= '0;
            rx_byte    <= '0;
            rx_tgl     <= 1'b0;
        end else begin
            bit_cnt    <= next_bit_cnt;
            rx_aligned <= (next_bit_cnt == BIT_ZERO);
            rx_sh      <= {rx_sh[6:0], SERIAL_IN};
            if (next_bit_cnt == BIT_ZERO) begin
                rx_byte <= {rx_sh[6:0], SERIAL_IN};
                rx_tgl  <= ~rx_tgl;
            end
        end
    end

    // Byte held in tx_byte is picked up at each byte boundary
    always_ff @(negedge SERIAL_CLOCK or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            tx_sh         <= '0;
            SERIAL_OUT    <= 1'b0;
            SERIAL_OUT_EN <= 1'b0;
        end else if (!first && bit_cnt == BIT_ZERO) begin
            tx_sh         <= {tx_byte[6:0], 1'b0};
            SERIAL_OUT    <= tx_byte[7];
            SERIAL_OUT_EN <= 1'b1;
        end else begin
            tx_sh      <= {tx_sh[6:0], 1'b0};
            SERIAL_OUT <= tx_sh[7];
        end
    end

    // Select resets low so a select held at power-up is no transition
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cs_s1 <= 1'b0;
            cs_s2 <= 1'b0;
            cs_s3 <= 1'b0;
            cs_s4 <= 1'b0;
            sel_s1 <= 1'b1;
            sel_s2 <= 1'b1;
            tg_s1 <= 1'b0;
            tg_s2 <= 1'b0;
            tg_s3 <= 1'b0;
            al_s1 <= 1'b1;
            al_s2 <= 1'b1;
            wp_s1 <= 1'b1;
            wp_s2 <= 1'b1;
        end else begin
            cs_s1 <= CHIP_SELECT_N;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            cs_s4 <= cs_s3;
            sel_s1 <= CHIP_SELECT_N;
            sel_s2 <= sel_s1;
            tg_s1 <= rx_tgl;
            tg_s2 <= tg_s1;
            tg_s3 <= tg_s2;
            al_s1 <= rx_aligned;
            al_s2 <= al_s1;
            wp_s1 <= WRITE_PROTECT_N;
            wp_s2 <= wp_s1;
        end
    end

    // End seen a cycle late so the last byte is always decoded first
    assign selected  = ~sel_s2;
    assign cs_fall   = cs_s3 & ~cs_s2;
    assign frame_end = cs_s3 & ~cs_s4;
    assign byte_evt  = tg_s2 ^ tg_s3;
    assign next_addr = {addr[15:0], rx_byte};

    always_comb begin
        status                     = '0;
        status[ST_BUSY]            = eng_busy;
        status[ST_WEL]             = wel;
        status[ST_PROT +: PROT_W]  = protect_size;
        status[ST_LOCK]            = status_lock;
    end

    // Frame decoder
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state     <= S_IDLE;
            opc       <= CMD_NONE;
            addr      <= '0;
            addr_cnt  <= '0;
            data_cnt  <= '0;
            data_seen <= 1'b0;
            stat_new  <= '0;
            stat_seen <= 1'b0;
        end else if (cs_fall) begin
            state     <= S_CMD;
            opc       <= CMD_NONE;
            addr_cnt  <= '0;
            data_cnt  <= '0;
            data_seen <= 1'b0;
            stat_seen <= 1'b0;
        end else if (frame_end) begin
            state <= S_IDLE;
        end else if (byte_evt) begin
            case (state)
                S_CMD: begin
                    opc <= rx_byte;
                    if (!armed) begin
                        state <= S_SKIP;
                    end else if (takes_addr(rx_byte) &&
                                 !(eng_busy && rx_byte != CMD_READ)) begin
                        state <= S_ADDR;
                    end else if (rx_byte == CMD_WR_STATUS) begin
                        state <= S_STAT_IN;
                    end else begin
                        state <= S_SKIP;
                    end
                end
                S_ADDR: begin
                    addr     <= next_addr;
                    addr_cnt <= addr_cnt + 2'h1;
                    if (addr_cnt == ADDR_LAST) begin
                        if (opc == CMD_READ) begin
                            state <= S_READ;
                        end else if (takes_data(opc)) begin
                            state <= S_DATA;
                        end else begin
                            state <= S_SKIP;
                        end
                    end
                end
                S_DATA: begin
                    data_cnt  <= data_cnt + 8'h1;
                    data_seen <= 1'b1;
                end
                S_STAT_IN: begin
                    stat_new  <= rx_byte;
                    stat_seen <= 1'b1;
                    state     <= S_SKIP;
                end
                default: begin
                end
            endcase
        end
    end

    // Data bytes wrap inside the addressed page
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            buf_clr  <= 1'b0;
            buf_wr   <= 1'b0;
            buf_idx  <= '0;
            buf_data <= '0;
        end else begin
            buf_clr  <= byte_evt && state == S_CMD && takes_data(rx_byte)
                        && !eng_busy;
            buf_wr   <= byte_evt && state == S_DATA;
            buf_idx  <= addr[PAGE_W-1:0] + data_cnt;
            buf_data <= rx_byte;
        end
    end

    // Reads need one dummy byte: the fetch cannot beat half a bit time
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rd_ptr  <= '0;
            refresh <= 1'b0;
            tx_byte <= '0;
        end else begin
            refresh <= 1'b0;
            if (byte_evt && state == S_ADDR && addr_cnt == ADDR_LAST &&
                opc == CMD_READ) begin
                rd_ptr  <= next_addr[ADDR_W-1:0];
                refresh <= 1'b1;
            end else if (byte_evt && state == S_READ) begin
                rd_ptr  <= rd_ptr + ADDR_W'(1);
                refresh <= 1'b1;
            end
            // Only changed away from byte boundaries, so the link sees
            // a settled word
            if (refresh) begin
                tx_byte <= rd_data;
            end else if (state != S_READ && (byte_evt || !selected)) begin
                tx_byte <= status;
            end
        end
    end

    assign accept = armed && al_s2 && !eng_busy;
    assign frozen = status_lock && !wp_s2;
    assign locked = sector_locked(addr[SECT_W +: SECT_BITS],
                                  protect_size);

    // Commands act when select rises
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            armed        <= 1'b0;
            wel          <= 1'b0;
            protect_size <= PROT_NONE;
            status_lock  <= 1'b0;
            eng_start    <= 1'b0;
            eng_op       <= OP_PAGE_WRITE;
        end else begin
            eng_start <= 1'b0;
            if (cs_fall) begin
                armed <= 1'b1;
            end
            if (eng_done) begin
                wel <= 1'b0;
            end
            if (frame_end && accept) begin
                case (opc)
                    CMD_WR_EN:  wel <= 1'b1;
                    CMD_WR_DIS: wel <= 1'b0;
                    CMD_WR_STATUS: begin
                        if (wel && stat_seen && !frozen) begin
                            protect_size <= stat_new[ST_PROT +: PROT_W];
                            status_lock  <= stat_new[ST_LOCK];
                            wel          <= 1'b0;
                        end
                    end
                    CMD_PAGE_WRITE, CMD_PAGE_PROG: begin
                        if (wel && addr_cnt == ADDR_DONE && data_seen &&
                            !locked) begin
                            eng_start <= 1'b1;
                            eng_op    <= (opc == CMD_PAGE_WRITE) ?
                                         OP_PAGE_WRITE : OP_PAGE_PROG;
                        end
                    end
                    CMD_PAGE_ERASE, CMD_SUB_ERASE, CMD_SECT_ERASE: begin
                        if (wel && addr_cnt == ADDR_DONE && !locked) begin
                            eng_start <= 1'b1;
                            if (opc == CMD_PAGE_ERASE) begin
                                eng_op <= OP_ERASE_PAGE;
                            end else if (opc == CMD_SUB_ERASE) begin
                                eng_op <= OP_ERASE_SUB;
                            end else begin
                                eng_op <= OP_ERASE_SECT;
                            end
                        end
                    end
                    CMD_BULK_ERASE: begin
                        if (wel && protect_size == PROT_NONE) begin
                            eng_start <= 1'b1;
                            eng_op    <= OP_ERASE_ALL;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Stays active after deselect until the internal cycle ends
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            POWER_ACTIVE <= 1'b0;
            BUSY         <= 1'b0;
        end else begin
            POWER_ACTIVE <= selected || eng_busy;
            BUSY         <= eng_busy;
        end
    end

    flash_array_engine #(
        .ADDR_W   (ADDR_W)
    ) u_engine (
        .clk      (CLOCK),
        .rst_n    (RST_N),
        .start    (eng_start),
        .op       (eng_op),
        .addr     (addr[ADDR_W-1:0]),
        .buf_clr  (buf_clr),
        .buf_wr   (buf_wr),
        .buf_idx  (buf_idx),
        .buf_data (buf_data),
        .rd_addr  (rd_ptr),
        .rd_data  (rd_data),
        .busy     (eng_busy),
        .done     (eng_done)
    );

endmodule // paged_serial_flash_spi_port

`default_nettype wire

// ==== rtl/flash_spi_pkg.sv ====
/*
 * Shared constants for the paged serial flash port: array geometry,
 * command codes, status layout, operation kinds and the protection map.
 * Assumes the importing modules run a byte-wide serial front end.
 */
`default_nettype none

package flash_spi_pkg;

    // Array geometry
    localparam int BYTE_W     = 8;
    localparam int ADDR_BITS  = 21;
    localparam int ADDR_BYTES = 3;
    localparam int PAGE_W     = 8;
    localparam int SUBSECT_W  = 12;
    localparam int SECT_W     = 16;
    localparam int SECT_BITS  = 5;
    localparam int PAGE_BYTES = 1 << PAGE_W;
    localparam logic [BYTE_W-1:0] ERASED = 8'hff;
    localparam logic [5:0] SECT_COUNT = 6'h20;

    // Serial bit and address byte counting
    localparam logic [2:0] BIT_ZERO  = 3'h0;
    localparam logic [2:0] BIT_FIRST = 3'h1;
    localparam logic [1:0] ADDR_LAST = 2'h2;
    localparam logic [1:0] ADDR_DONE = 2'h3;

    // Status byte layout
    localparam int ST_BUSY = 0;
    localparam int ST_WEL  = 1;
    localparam int ST_PROT = 2;
    localparam int PROT_W  = 3;
    localparam int ST_LOCK = 7;
    localparam logic [PROT_W-1:0] PROT_NONE     = 3'h0;
    localparam logic [PROT_W-1:0] PROT_ALL_FROM = 3'h6;

    // Command codes
    localparam logic [7:0] CMD_NONE       = 8'h00;
    localparam logic [7:0] CMD_WR_EN      = 8'h10;
    localparam logic [7:0] CMD_WR_DIS     = 8'h11;
    localparam logic [7:0] CMD_RD_STATUS  = 8'h12;
    localparam logic [7:0] CMD_WR_STATUS  = 8'h13;
    localparam logic [7:0] CMD_READ       = 8'h14;
    localparam logic [7:0] CMD_PAGE_WRITE = 8'h15;
    localparam logic [7:0] CMD_PAGE_PROG  = 8'h16;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h17;
    localparam logic [7:0] CMD_SUB_ERASE  = 8'h18;
    localparam logic [7:0] CMD_SECT_ERASE = 8'h19;
    localparam logic [7:0] CMD_BULK_ERASE = 8'h1a;

    typedef enum logic [2:0] {
        OP_PAGE_WRITE,
        OP_PAGE_PROG,
        OP_ERASE_PAGE,
        OP_ERASE_SUB,
        OP_ERASE_SECT,
        OP_ERASE_ALL
    } op_e;

    // Protected region grows down from the top sector
    function automatic logic sector_locked(logic [SECT_BITS-1:0] sect,
                                           logic [PROT_W-1:0]    size);
        logic [5:0] span;
        if (size == PROT_NONE) begin
            span = 6'h0;
        end else if (size >= PROT_ALL_FROM) begin
            span = SECT_COUNT;
        end else begin
            span = 6'(6'h1 << (size - 3'h1));
        end
        return {1'b0, sect} >= 6'(SECT_COUNT - span);
    endfunction

endpackage

`default_nettype wire

// ==== rtl/flash_array_engine.sv ====
/*
 * Storage array, page buffer and internal cycle sequencer.
 * Assumes the caller starts an operation only while busy is low and
 * fills the page buffer only between operations.
 */
`default_nettype none

module flash_array_engine
    import flash_spi_pkg::*;
#(
    parameter int ADDR_W = ADDR_BITS
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Operation request
    input  wire logic              start,
    input  wire op_e               op,
    input  wire logic [ADDR_W-1:0] addr,
    // Page buffer fill
    input  wire logic              buf_clr,
    input  wire logic              buf_wr,
    input  wire logic [PAGE_W-1:0] buf_idx,
    input  wire logic [BYTE_W-1:0] buf_data,
    // Array read
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [BYTE_W-1:0] rd_data,
    // Cycle state
    output logic                   busy,
    output logic                   done
);

    typedef enum {E_IDLE, E_LOAD, E_ERASE, E_PROG} phase_e;

    logic [BYTE_W-1:0]     mem [0:(1<<ADDR_W)-1];
    logic [BYTE_W-1:0]     pbuf [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] pmask;
    phase_e                phase;
    op_e                   cur_op;
    logic [ADDR_W-1:0]     base;
    logic [ADDR_W-1:0]     idx;
    logic [ADDR_W-1:0]     last;
    logic [ADDR_W-1:0]     cur;
    logic [PAGE_W-1:0]     pidx;

    function automatic logic [ADDR_W-1:0] span_mask(op_e o);
        int w;
        case (o)
            OP_ERASE_SUB:  w = SUBSECT_W;
            OP_ERASE_SECT: w = SECT_W;
            OP_ERASE_ALL:  w = ADDR_W;
            default:       w = PAGE_W;
        endcase
        return {ADDR_W{1'b1}} >> (ADDR_W - w);
    endfunction

    assign cur     = base | idx;
    assign pidx    = idx[PAGE_W-1:0];
    assign rd_data = mem[rd_addr];
    assign busy    = (phase != E_IDLE);

    // Reset drops any running cycle; the span may be left half done
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase  <= E_IDLE;
            cur_op <= OP_PAGE_WRITE;
            base   <= '0;
            last   <= '0;
            idx    <= '0;
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                cur_op <= op;
                base   <= addr & ~span_mask(op);
                last   <= span_mask(op);
                idx    <= '0;
                case (op)
                    OP_PAGE_WRITE: phase <= E_LOAD;
                    OP_PAGE_PROG:  phase <= E_PROG;
                    default:       phase <= E_ERASE;
                endcase
            end else if (busy) begin
                if (idx == last) begin
                    idx <= '0;
                    case (phase)
                        E_LOAD: phase <= E_ERASE;
                        E_ERASE: begin
                            if (cur_op == OP_PAGE_WRITE) begin
                                phase <= E_PROG;
                            end else begin
                                phase <= E_IDLE;
                                done  <= 1'b1;
                            end
                        end
                        default: begin
                            phase <= E_IDLE;
                            done  <= 1'b1;
                        end
                    endcase
                end else begin
                    idx <= idx + ADDR_W'(1);
                end
            end
        end
    end

    // Programming only clears bits
    always_ff @(posedge clk) begin
        if (phase == E_ERASE) begin
            mem[cur] <= ERASED;
        end else if (phase == E_PROG &&
                     (cur_op == OP_PAGE_WRITE || pmask[pidx])) begin
            mem[cur] <= mem[cur] & pbuf[pidx];
        end
    end

    // Unsent bytes are filled from the page before it is erased
    always_ff @(posedge clk) begin
        if (buf_wr) begin
            pbuf[buf_idx] <= buf_data;
        end else if (phase == E_LOAD && !pmask[pidx]) begin
            pbuf[pidx] <= mem[cur];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pmask <= '0;
        end else if (buf_clr) begin
            pmask <= '0;
        end else if (buf_wr) begin
            pmask[buf_idx] <= 1'b1;
        end
    end

endmodule // flash_array_engine

`default_nettype wire

// ==== sim/spi_master.sv ====
/* Bus master model for the flash serial link, modes 0 and 3.
   Assumes the bench sets the mode and fills the transmit bytes. */
`default_nettype none
module spi_master (
    // Serial link
    output var logic sclk,
    output var logic cs_n,
    output var logic si,
    input wire logic so,
    input wire logic so_en
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] txb [0:259];
    logic [7:0] rxb [0:259];
    logic       cpol = 1'b0;
    logic       last = 1'b0;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // Clock stands still at its idle level outside frames
    task automatic frame(input logic [7:0] cmd, input logic [23:0] adr,
                         input int nbytes, input int extra);
        {txb[0], txb[1], txb[2], txb[3]} = {cmd, adr};
        sclk = cpol;
        #15 cs_n = 1'b0;
        for (int i = 0; i < nbytes * 8 + extra; i++) begin
            sclk = 1'b0;
            si = txb[i / 8][7 - i % 8];
            #15 sclk = 1'b1;
            // Released line reads as the inverse of its last bit
            last = so_en ? so : ~last;
            rxb[i / 8][7 - i % 8] = last;
            #15;
        end
        sclk = cpol;
        #15 cs_n = 1'b1;
        #300;
    endtask
endmodule // spi_master
`default_nettype wire

// ==== sim/paged_serial_flash_spi_port_sva.sv ====
/* Pin checker for the flash serial port.
   Assumes it is bound to the top module. */
`default_nettype none
module paged_serial_flash_spi_port_sva (
    // Clocks and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic SERIAL_CLOCK,
    // Link and state
    input wire logic CHIP_SELECT_N,
    input wire logic SERIAL_OUT,
    input wire logic SERIAL_OUT_EN,
    input wire logic POWER_ACTIVE,
    input wire logic BUSY
);
    timeunit 1ns;
    timeprecision 100ps;
    logic held;
    // Cleared by select so a new frame never sees old bits
    always_ff @(posedge SERIAL_CLOCK or posedge CHIP_SELECT_N)
        if (CHIP_SELECT_N)
            held <= 1'b0;
        else
            held <= SERIAL_OUT;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    sequence s_idle; (CHIP_SELECT_N && !BUSY)[*8]; endsequence
    sequence s_sel; (!CHIP_SELECT_N)[*5]; endsequence
    property p_fall; @(negedge SERIAL_CLOCK) disable iff (!RST_N ||
        CHIP_SELECT_N) SERIAL_OUT == held; endproperty
    a_fall: assert property (p_fall) else $error("out moved on rise");
    property p_desel; CHIP_SELECT_N |-> !SERIAL_OUT_EN; endproperty
    a_desel: assert property (p_desel) else $error("driven deselected");
    property p_rel; $rose(RST_N) && CHIP_SELECT_N |->
        (!BUSY && !SERIAL_OUT_EN && !POWER_ACTIVE)[*3]; endproperty
    a_rel: assert property (p_rel) else $error("not quiet at reset");
    property p_sel; s_sel |-> POWER_ACTIVE; endproperty
    a_sel: assert property (p_sel) else $error("select not active");
    property p_stby; s_idle |-> !POWER_ACTIVE; endproperty
    a_stby: assert property (p_stby) else $error("no standby");
    property p_bpwr; BUSY[*4] |-> POWER_ACTIVE; endproperty
    a_bpwr: assert property (p_bpwr) else $error("standby while busy");
    property p_start; $rose(BUSY) |-> $past(CHIP_SELECT_N, 2); endproperty
    a_start: assert property (p_start) else $error("early start");
    property p_hold; $rose(BUSY) |-> BUSY[*8]; endproperty
    a_hold: assert property (p_hold) else $error("short cycle");
endmodule // paged_serial_flash_spi_port_sva
bind paged_serial_flash_spi_port paged_serial_flash_spi_port_sva u_sva (
    .CLOCK(CLOCK), .RST_N(RST_N), .SERIAL_CLOCK(SERIAL_CLOCK),
    .CHIP_SELECT_N(CHIP_SELECT_N), .SERIAL_OUT(SERIAL_OUT),
    .SERIAL_OUT_EN(SERIAL_OUT_EN), .POWER_ACTIVE(POWER_ACTIVE),
    .BUSY(BUSY));
`default_nettype wire

// ==== sim/paged_serial_flash_spi_port_tb.sv ====
/* Bench for the flash serial port: status, page write, refusal.
   Assumes the master model drives the link. */
`default_nettype none
module paged_serial_flash_spi_port_tb
    import flash_spi_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wp_n = 1'b1;
    logic sclk, cs_n, si, so, so_en, pwr, busy;
    int   n_fail = 0;
    int   total_checks = 0;
    always #20 clk = ~clk;
    paged_serial_flash_spi_port u_paged_serial_flash_spi_port (
        .CLOCK(clk), .RST_N(rst_n), .SERIAL_CLOCK(sclk),
        .CHIP_SELECT_N(cs_n), .SERIAL_IN(si), .WRITE_PROTECT_N(wp_n),
        .SERIAL_OUT(so), .SERIAL_OUT_EN(so_en), .POWER_ACTIVE(pwr),
        .BUSY(busy));
    spi_master u_spi_master (
        .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_en(so_en));
    task automatic stop_test;
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, act);
        total_checks++;
        if (act !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, act);
        end
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 3000; i++) begin
            @(posedge clk);
            if (i > 12 && busy === 1'b0)
                return;
        end
        check("busy", 8'h00, 8'h01);
        stop_test;
    endtask
    task automatic t_status;
        for (int m = 0; m < 2; m++) begin
            u_spi_master.cpol = m[0];
            u_spi_master.frame(CMD_RD_STATUS, 24'h0, 2, 0);
            check("status", 8'h00, u_spi_master.rxb[1]);
        end
        $display("test status done");
    endtask
    task automatic t_write;
        u_spi_master.frame(CMD_WR_EN, 24'h0, 1, 0);
        u_spi_master.frame(CMD_PAGE_ERASE, 24'h000100, 4, 0);
        wait_idle;
        u_spi_master.frame(CMD_WR_EN, 24'h0, 1, 0);
        u_spi_master.txb[4] = 8'h5a;
        u_spi_master.frame(CMD_PAGE_WRITE, 24'h000105, 5, 0);
        wait_idle;
        u_spi_master.frame(CMD_READ, 24'h000104, 7, 0);
        check("kept", 8'hff, u_spi_master.rxb[5]);
        check("written", 8'h5a, u_spi_master.rxb[6]);
        $display("test write done");
    endtask
    task automatic t_refuse;
        u_spi_master.frame(CMD_WR_EN, 24'h0, 1, 0);
        u_spi_master.txb[4] = 8'h33;
        u_spi_master.txb[5] = 8'h00;
        u_spi_master.frame(CMD_PAGE_WRITE, 24'h000105, 5, 3);
        u_spi_master.frame(CMD_RD_STATUS, 24'h0, 2, 0);
        check("status", 8'h02, u_spi_master.rxb[1]);
        u_spi_master.frame(CMD_READ, 24'h000105, 6, 0);
        check("unchanged", 8'h5a, u_spi_master.rxb[5]);
        $display("test refuse done");
    endtask
    task automatic t_protect;
        u_spi_master.frame(CMD_WR_EN, 24'h0, 1, 0);
        u_spi_master.frame(CMD_WR_STATUS, 24'h840000, 2, 0);
        @(posedge clk);
        #1 wp_n = 1'b0;
        u_spi_master.frame(CMD_WR_EN, 24'h0, 1, 0);
        u_spi_master.frame(CMD_WR_STATUS, 24'h0, 2, 0);
        u_spi_master.frame(CMD_SECT_ERASE, 24'h1f0000, 4, 0);
        u_spi_master.frame(CMD_RD_STATUS, 24'h0, 2, 0);
        check("frozen", 8'h86, u_spi_master.rxb[1]);
        u_spi_master.frame(CMD_PAGE_ERASE, 24'h000200, 4, 0);
        repeat (20) @(posedge clk);
        check("started", 8'h01, {7'h0, busy});
        #1 rst_n = 1'b0;
        @(posedge clk);
        #1 rst_n = 1'b1;
        check("abort", 8'h00, {7'h0, busy});
        repeat (4) @(posedge clk);
        u_spi_master.frame(CMD_RD_STATUS, 24'h0, 2, 0);
        check("cleared", 8'h00, u_spi_master.rxb[1]);
        $display("test protect done");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        t_status;
        t_write;
        t_refuse;
        t_protect;
        stop_test;
    end
endmodule // paged_serial_flash_spi_port_tb
`default_nettype wire
